// file: core/sscs_pkg.sv
// constants and types for the serial status and clock select block
package sscs_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [4:0] ADR_MODE = 5'h00;
  localparam logic [4:0] ADR_BRATE = 5'h04;
  localparam logic [4:0] ADR_CTRL = 5'h08;
  localparam logic [4:0] ADR_TXD = 5'h0c;
  localparam logic [4:0] ADR_STAT = 5'h10;
  localparam logic [4:0] ADR_RXD = 5'h14;
  // serial_mode_reg fields
  localparam int MODE_SYNC = 7;
  localparam int MODE_PAR_EN = 5;
  localparam int MODE_PAR_ODD = 4;
  localparam int MODE_STOP2 = 3;
  localparam int MODE_MP_EN = 2;
  // serial_control_reg fields
  localparam int CTRL_TX_IRQ_EN = 7;
  localparam int CTRL_RX_IRQ_EN = 6;
  localparam int CTRL_TX_EN = 5;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_TX_FINISHED_IRQ_EN = 2;
  localparam int CTRL_CLOCK_SOURCE_EXTERNAL_SEL = 1;
  localparam int CTRL_CLOCK_OUTPUT_SEL = 0;
  // serial_status_reg fields
  localparam int ST_TX_HOLDING_EMPTY = 7;
  localparam int ST_RX_HOLDING_FULL = 6;
  localparam int ST_OVR = 5;
  localparam int ST_FRM = 4;
  localparam int ST_PAR = 3;
  localparam int ST_TX_FINISHED = 2;
  localparam int ST_RX_MULTIPROC_BIT = 1;
  localparam int ST_TX_MULTIPROC_BIT = 0;
  // flags that software clears by writing 0 after reading 1
  localparam logic [7:0] ST_W0_MASK = 8'hf8;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BRATE_RESET = 8'hff;
  localparam logic [7:0] STAT_RESET = 8'h84;
  // clock option codes
  localparam logic [1:0] CKE_INT_OUT = 2'h1;
  // frame timing, in oversample ticks and bits
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] ASYNC_BASE_LEN = 4'ha;
  localparam logic [3:0] SYNC_LEN = 4'h8;
  localparam logic [3:0] RX_ASYNC_BASE = 4'h8;
  localparam logic [3:0] RX_SYNC_LAST = 4'h7;
  localparam logic [11:0] FRAME_IDLE = 12'hfff;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} sscs_rx_state_t;
endpackage

// file: core/sscs_core.sv
// serial interface core: status flags, clock pin selection and framing engines
// Overview of operation
// - tx_finished_irq drops when both empty and finished flags clear, or enable clears
// - two clock-enable bits choose pin function: port, clock out or clock in
// - async internal clock with output drives the pin at the bit rate
// - status register becomes 84 hex on reset and on standby entry
// - error and empty flags clear by writing 0 after reading 1; 1 does nothing
// - tx_finished and rx_multiproc_bit are read only
// - tx_holding_empty sets on disable or transfer; clears on data write or 0-write
// - rx_holding_full sets on clean reception; clears on data read or 0-write
// - clearing receive enable keeps received data and receive flags
// - reception while full sets overrun and drops the new character
// - overrun stops reception, and in synchronous mode also transmission
// - framing flag sets when the first stop bit is 0; second never checked
// - framing error still stores the character but halts reception
// - parity mismatch sets parity flag, stores character, halts reception
// - tx_finished sets on disable or when empty at last bit; clears like empty
// - multiprocessor reception captures the received multiprocessor bit
// - tx_multiproc_bit is appended only in async frames with the function on
// - finished request rises when no data waits as the final bit goes out
// - receive irq enable gates both full and error requests
`timescale 1ns/100ps
module sscs_core (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic standby_req,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_data_pin,
  output logic tx_data_pin,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic tx_finished_irq
);
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [7:0] brate_q;
  logic [7:0] tdr_q;
  logic [7:0] rdr_q;
  logic [7:0] stat_q;
  logic [7:0] armed_q;
  logic [7:0] div_q;
  logic [3:0] ph_q;
  logic rxd_s1_q;
  logic rxd_s2_q;
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_s3_q;
  logic tx_busy_q;
  logic [11:0] tx_frame_q;
  logic [3:0] tx_left_q;
  sscs_pkg::sscs_rx_state_t rx_state_q;
  logic [3:0] rx_os_q;
  logic [3:0] rx_idx_q;
  logic [9:0] rx_shift_q;
  logic rx_done_q;
  logic [7:0] rd_mux;

  // build a whole outgoing character: {bit count, bits lsb first, idle ones above}
  function automatic logic [15:0] build_frame(input logic [7:0] data, input logic [7:0] mode,
                                              input logic mpb);
    logic [11:0] fr;
    logic [3:0] len;
    fr = sscs_pkg::FRAME_IDLE;
    len = sscs_pkg::SYNC_LEN;
    if (mode[sscs_pkg::MODE_SYNC])
    begin
      fr[7:0] = data;
    end
    else
    begin
      fr[0] = 1'b0;
      fr[8:1] = data;
      len = sscs_pkg::ASYNC_BASE_LEN + {3'h0, mode[sscs_pkg::MODE_STOP2]};
      if (mode[sscs_pkg::MODE_MP_EN])
      begin
        fr[9] = mpb;
        len = len + 4'h1;
      end
      else if (mode[sscs_pkg::MODE_PAR_EN])
      begin
        fr[9] = (^data) ^ mode[sscs_pkg::MODE_PAR_ODD];
        len = len + 4'h1;
      end
    end
    build_frame = {len, fr};
  endfunction

  wire mode_sync = mode_q[sscs_pkg::MODE_SYNC];
  wire extra_bit = mode_q[sscs_pkg::MODE_MP_EN] | mode_q[sscs_pkg::MODE_PAR_EN];
  wire ext_clk = ctrl_q[sscs_pkg::CTRL_CLOCK_SOURCE_EXTERNAL_SEL];
  wire tx_en = ctrl_q[sscs_pkg::CTRL_TX_EN];
  wire rx_en = ctrl_q[sscs_pkg::CTRL_RX_EN];
  wire any_err = stat_q[sscs_pkg::ST_OVR] | stat_q[sscs_pkg::ST_FRM] | stat_q[sscs_pkg::ST_PAR];
  wire tx_stall = mode_sync & any_err;
  wire tx_go = ~stat_q[sscs_pkg::ST_TX_HOLDING_EMPTY] & ~tx_stall;

  // bus strobes: an access is acted on in the cycle before ack shows; a write only when wb_sel_i[0] is set
  wire acc = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire rd = acc & ~wb_we_i;
  wire stat_wr = wr & (wb_adr_i == sscs_pkg::ADR_STAT);
  wire stat_rd = rd & (wb_adr_i == sscs_pkg::ADR_STAT);
  wire txd_wr = wr & (wb_adr_i == sscs_pkg::ADR_TXD);
  wire rxd_rd = rd & (wb_adr_i == sscs_pkg::ADR_RXD);

  // timing: oversample tick from the divider or from the external pin
  wire div_tick = (div_q >= brate_q);
  wire ext_rise = sck_s2_q & ~sck_s3_q;
  wire ext_fall = ~sck_s2_q & sck_s3_q;
  wire os_tick = ext_clk ? (~mode_sync & ext_rise) : div_tick;
  wire sync_run = tx_busy_q | (rx_state_q == sscs_pkg::RX_BITS);
  wire tx_bit_edge = (mode_sync & ext_clk) ? ext_fall : (os_tick & (ph_q == sscs_pkg::OS_LAST));
  wire rx_sync_sample = ext_clk ? ext_rise : (os_tick & (ph_q == sscs_pkg::OS_MID));
  wire tx_last = tx_busy_q & (tx_left_q == 4'h1);
  wire tx_load = tx_bit_edge & tx_en & ~standby_req & (~tx_busy_q | tx_last) & tx_go;
  wire tx_end = tx_bit_edge & tx_en & ~standby_req & tx_last & ~tx_go;
  wire [3:0] rx_last_idx = mode_sync ? sscs_pkg::RX_SYNC_LAST
                                     : sscs_pkg::RX_ASYNC_BASE + {3'h0, extra_bit};
  wire rx_stop = extra_bit ? rx_shift_q[9] : rx_shift_q[8];
  wire rx_par_bad = (^rx_shift_q[8:0]) != mode_q[sscs_pkg::MODE_PAR_ODD];

  // pin synchronisers; the second stage feeds logic, and the clock pin's third stage also feeds its edge detect
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
    end
    else
    begin
      rxd_s1_q <= rx_data_pin;
      rxd_s2_q <= rxd_s1_q;
      sck_s1_q <= serial_clock_pin_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  // wishbone slave and software-written registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      mode_q <= sscs_pkg::MODE_RESET;
      ctrl_q <= sscs_pkg::CTRL_RESET;
      brate_q <= sscs_pkg::BRATE_RESET;
      tdr_q <= 8'h00;
    end
    else
    begin
      ack_q <= acc;
      if (rd)
      begin
        rdata_q <= {24'h00_0000, rd_mux};
      end
      if (standby_req)
      begin
        mode_q <= sscs_pkg::MODE_RESET;
        ctrl_q <= sscs_pkg::CTRL_RESET;
        brate_q <= sscs_pkg::BRATE_RESET;
      end
      else if (wr)
      begin
        if (wb_adr_i == sscs_pkg::ADR_MODE)
        begin
          mode_q <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == sscs_pkg::ADR_BRATE)
        begin
          brate_q <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == sscs_pkg::ADR_CTRL)
        begin
          ctrl_q <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == sscs_pkg::ADR_TXD)
        begin
          tdr_q <= wb_dat_i[7:0];
        end
      end
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (wb_adr_i == sscs_pkg::ADR_MODE)
      rd_mux = mode_q;
    else if (wb_adr_i == sscs_pkg::ADR_BRATE)
      rd_mux = brate_q;
    else if (wb_adr_i == sscs_pkg::ADR_CTRL)
      rd_mux = ctrl_q;
    else if (wb_adr_i == sscs_pkg::ADR_TXD)
      rd_mux = tdr_q;
    else if (wb_adr_i == sscs_pkg::ADR_STAT)
      rd_mux = stat_q;
    else if (wb_adr_i == sscs_pkg::ADR_RXD)
      rd_mux = rdr_q;
  end

  // rate divider and bit phase; the phase also shapes the clock driven on the pin
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q <= 8'h00;
      ph_q <= sscs_pkg::OS_LAST;
    end
    else
    begin
      div_q <= div_tick ? 8'h00 : div_q + 8'h01;
      // synchronous clock idles high and starts cleanly with a falling edge
      if (standby_req || (mode_sync && !sync_run))
        ph_q <= sscs_pkg::OS_LAST;
      else if (os_tick)
        ph_q <= ph_q + 4'h1;
    end
  end

  // transmit engine; a new character follows the last bit with no gap
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_busy_q <= 1'b0;
      tx_frame_q <= sscs_pkg::FRAME_IDLE;
      tx_left_q <= 4'h0;
    end
    else if (standby_req || !tx_en)
    begin
      tx_busy_q <= 1'b0;
      tx_frame_q <= sscs_pkg::FRAME_IDLE;
      tx_left_q <= 4'h0;
    end
    else if (tx_bit_edge)
    begin
      if (tx_busy_q && !tx_last)
      begin
        tx_frame_q <= {1'b1, tx_frame_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
      else if (tx_go)
      begin
        {tx_left_q, tx_frame_q} <= build_frame(tdr_q, mode_q, stat_q[sscs_pkg::ST_TX_MULTIPROC_BIT]);
        tx_busy_q <= 1'b1;
      end
      else
      begin
        tx_busy_q <= 1'b0;
        tx_frame_q <= sscs_pkg::FRAME_IDLE;
        tx_left_q <= 4'h0;
      end
    end
  end

  // receive engine; disabling only stops sampling, results stay where they are
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state_q <= sscs_pkg::RX_IDLE;
      rx_os_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_shift_q <= 10'h000;
      rx_done_q <= 1'b0;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (standby_req || !rx_en)
      begin
        rx_state_q <= sscs_pkg::RX_IDLE;
      end
      else
      begin
        case (rx_state_q)
          sscs_pkg::RX_IDLE:
          begin
            rx_os_q <= 4'h0;
            rx_idx_q <= 4'h0;
            if (!any_err)
            begin
              // with the internal synchronous clock, reception only starts when there is room for data
              if (mode_sync && (ext_clk || !stat_q[sscs_pkg::ST_RX_HOLDING_FULL]))
                rx_state_q <= sscs_pkg::RX_BITS;
              else if (!mode_sync && os_tick && !rxd_s2_q)
                rx_state_q <= sscs_pkg::RX_START;
            end
          end
          sscs_pkg::RX_START:
          begin
            if (os_tick)
            begin
              rx_os_q <= rx_os_q + 4'h1;
              if (rx_os_q == sscs_pkg::OS_MID)
              begin
                rx_os_q <= 4'h0;
                // a glitch shorter than half a bit is not a start bit
                rx_state_q <= rxd_s2_q ? sscs_pkg::RX_IDLE : sscs_pkg::RX_BITS;
              end
            end
          end
          sscs_pkg::RX_BITS:
          begin
            if (!mode_sync && os_tick)
              rx_os_q <= rx_os_q + 4'h1;
            if (mode_sync ? rx_sync_sample : (os_tick && rx_os_q == sscs_pkg::OS_LAST))
            begin
              rx_shift_q[rx_idx_q] <= rxd_s2_q;
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_last_idx)
              begin
                rx_done_q <= 1'b1;
                rx_state_q <= sscs_pkg::RX_IDLE;
              end
            end
          end
          default:
          begin
            rx_state_q <= sscs_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // status flags: clears are applied first so that a same-cycle set wins
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stat_q <= sscs_pkg::STAT_RESET;
      rdr_q <= 8'h00;
    end
    else if (standby_req)
    begin
      stat_q <= sscs_pkg::STAT_RESET;
    end
    else
    begin
      if (stat_wr)
      begin
        for (int b = 3; b < 8; b++)
        begin
          if (!wb_dat_i[b] && armed_q[b])
            stat_q[b] <= 1'b0;
        end
        if (!wb_dat_i[sscs_pkg::ST_TX_HOLDING_EMPTY] && armed_q[sscs_pkg::ST_TX_HOLDING_EMPTY])
          stat_q[sscs_pkg::ST_TX_FINISHED] <= 1'b0;
        stat_q[sscs_pkg::ST_TX_MULTIPROC_BIT] <= wb_dat_i[sscs_pkg::ST_TX_MULTIPROC_BIT];
      end
      if (txd_wr)
      begin
        stat_q[sscs_pkg::ST_TX_HOLDING_EMPTY] <= 1'b0;
        stat_q[sscs_pkg::ST_TX_FINISHED] <= 1'b0;
      end
      if (rxd_rd)
        stat_q[sscs_pkg::ST_RX_HOLDING_FULL] <= 1'b0;
      if (!tx_en || tx_load)
        stat_q[sscs_pkg::ST_TX_HOLDING_EMPTY] <= 1'b1;
      if (!tx_en || (tx_end && stat_q[sscs_pkg::ST_TX_HOLDING_EMPTY]))
        stat_q[sscs_pkg::ST_TX_FINISHED] <= 1'b1;
      if (rx_done_q)
      begin
        if (stat_q[sscs_pkg::ST_RX_HOLDING_FULL])
        begin
          stat_q[sscs_pkg::ST_OVR] <= 1'b1;
        end
        else
        begin
          rdr_q <= rx_shift_q[7:0];
          if (!mode_sync && mode_q[sscs_pkg::MODE_MP_EN])
            stat_q[sscs_pkg::ST_RX_MULTIPROC_BIT] <= rx_shift_q[8];
          if (!mode_sync && !rx_stop)
            stat_q[sscs_pkg::ST_FRM] <= 1'b1;
          else if (!mode_sync && mode_q[sscs_pkg::MODE_PAR_EN] &&
                   !mode_q[sscs_pkg::MODE_MP_EN] && rx_par_bad)
            stat_q[sscs_pkg::ST_PAR] <= 1'b1;
          else
            stat_q[sscs_pkg::ST_RX_HOLDING_FULL] <= 1'b1;
        end
      end
    end
  end

  // a flag may only be cleared after software has seen it at 1
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      armed_q <= 8'h00;
    else if (standby_req)
      armed_q <= 8'h00;
    else
      armed_q <= (armed_q | ({8{stat_rd}} & stat_q)) & stat_q & sscs_pkg::ST_W0_MASK;
  end

  // clock pin: bit-rate clock out in async mode, burst clock in sync mode
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_clock_pin_o <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
    end
    else
    begin
      serial_clock_pin_o <= ph_q[3];
      serial_clock_pin_oe <= ~ext_clk & ~standby_req &
                             (mode_sync | (ctrl_q[1:0] == sscs_pkg::CKE_INT_OUT));
    end
  end

  assign tx_data_pin = tx_frame_q[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign tx_empty_irq = ctrl_q[sscs_pkg::CTRL_TX_IRQ_EN] & stat_q[sscs_pkg::ST_TX_HOLDING_EMPTY];
  assign rx_full_irq = ctrl_q[sscs_pkg::CTRL_RX_IRQ_EN] & stat_q[sscs_pkg::ST_RX_HOLDING_FULL];
  assign rx_error_irq = ctrl_q[sscs_pkg::CTRL_RX_IRQ_EN] & any_err;
  assign tx_finished_irq = ctrl_q[sscs_pkg::CTRL_TX_FINISHED_IRQ_EN] & stat_q[sscs_pkg::ST_TX_FINISHED];
endmodule

// file: tb/sscs_core_props.sv
// port-level assertions for the serial status and clock select core
`timescale 1ns/100ps
module sscs_core_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic standby_req,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_data_pin,
  input wire logic tx_data_pin,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic tx_empty_irq,
  input wire logic rx_full_irq,
  input wire logic rx_error_irq,
  input wire logic tx_finished_irq
);
  logic take;
  logic wr_take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_take = take && wb_we_i;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  ack_next_a: assert property (take |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  standby_quiet_a: assert property (
    standby_req [*3] |-> !serial_clock_pin_oe && tx_data_pin
    && !(tx_empty_irq || rx_full_irq || rx_error_irq || tx_finished_irq))
    else $error("standby did not reset outputs");
  rd_clear_a: assert property (
    take && !wb_we_i && wb_adr_i == sscs_pkg::ADR_RXD |=> !rx_full_irq)
    else $error("data read left full request");
  full_hold_a: assert property (
    rx_full_irq && !wr_take && !(take && wb_adr_i == sscs_pkg::ADR_RXD) && !standby_req
    |=> rx_full_irq)
    else $error("full request dropped by itself");
  err_hold_a: assert property (
    rx_error_irq && !wr_take && !standby_req |=> rx_error_irq)
    else $error("error request dropped without write");
  tx_finished_hold_a: assert property (
    tx_finished_irq && !wr_take && !standby_req |=> tx_finished_irq)
    else $error("finished request dropped without write");
  err_nofull_a: assert property (
    $rose(rx_error_irq) && !$past(wr_take) |-> !$rose(rx_full_irq))
    else $error("error reception also set full");
  fin_idle_a: assert property ($rose(tx_finished_irq) |-> tx_data_pin)
    else $error("finished while line not idle");
  cover property (wr_take && wb_adr_i == sscs_pkg::ADR_TXD);
  cover property ($rose(rx_error_irq));
  cover property ($rose(tx_finished_irq));
  cover property (serial_clock_pin_oe && $rose(serial_clock_pin_o));
endmodule

bind sscs_core sscs_core_props u_props (.mclk, .resetn, .standby_req, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_data_pin,
  .tx_data_pin, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe,
  .tx_empty_irq, .rx_full_irq, .rx_error_irq, .tx_finished_irq);

// file: tb/sscs_partner.sv
// remote serial device: sends and captures async frames, drives link clock
`timescale 1ns/100ps
module sscs_partner (
  input wire logic mclk,
  input wire logic tx_line,
  output logic rx_line,
  output logic link_clk
);
  logic run_clk = 1'b0;
  initial rx_line = 1'b1;
  initial link_clk = 1'b0;
  // link clock stands low between frames; 200 ns period, no relation to mclk
  always #100 link_clk = run_clk ? ~link_clk : 1'b0;
  task automatic send(input logic [9:0] bits, input int n, input int bit_clk, input logic ext);
    run_clk = ext;
    @(posedge mclk);
    rx_line <= 1'b0;
    repeat (bit_clk) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= bits[i];
      repeat (bit_clk) @(posedge mclk);
    end
    rx_line <= 1'b1;
    repeat (2 * bit_clk) @(posedge mclk);
    run_clk = 1'b0;
  endtask
  task automatic grab(output logic [9:0] bits, input int bit_clk);
    int w;
    w = 0;
    bits = 10'h000;
    while (tx_line === 1'b1 && w < 5000)
    begin
      @(posedge mclk);
      w++;
    end
    repeat (bit_clk / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bit_clk) @(posedge mclk);
      bits[i] = tx_line;
    end
  endtask
endmodule

// file: tb/test_sscs_core.sv
// self-checking bench for the serial status and clock select core
`timescale 1ns/100ps
module test_sscs_core;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic standby_req = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_data_pin, tx_data_pin, serial_clock_pin_i;
  logic serial_clock_pin_o, serial_clock_pin_oe;
  logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_finished_irq;
  int err_total = 0;
  int checks = 0;
  logic [7:0] rd;
  logic [9:0] fr;
  always #12.5 mclk = ~mclk;
  sscs_core u_sscs_core (.mclk, .resetn, .standby_req, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_data_pin, .tx_data_pin,
    .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe, .tx_empty_irq,
    .rx_full_irq, .rx_error_irq, .tx_finished_irq);
  sscs_partner partner (.mclk(mclk), .tx_line(tx_data_pin), .rx_line(rx_data_pin),
    .link_clk(serial_clock_pin_i));
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkf(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    @(posedge mclk);
    while (wb_ack_o !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        complete_run();
      end
      @(posedge mclk);
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {2'b00, e}, {2'b00, rd});
  endtask
  task automatic t_tx;
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'ha4);
    bus(1'b1, sscs_pkg::ADR_MODE, 8'h04);
    bus(1'b1, sscs_pkg::ADR_BRATE, 8'h00);
    bus(1'b1, sscs_pkg::ADR_STAT, 8'hff);
    rchk("status after ones", sscs_pkg::ADR_STAT, 8'h85);
    chkf("finished irq", 1'b1, tx_finished_irq);
    fork
      partner.grab(fr, 16);
      begin
        bus(1'b1, sscs_pkg::ADR_TXD, 8'h5a);
        chkf("finished after load", 1'b0, tx_finished_irq);
      end
    join
    chk("tx frame", 10'h35a, fr);
    repeat (16) @(posedge mclk);
    chkf("finished at end", 1'b1, tx_finished_irq);
    rchk("status after frame", sscs_pkg::ADR_STAT, 8'h85);
    bus(1'b1, sscs_pkg::ADR_STAT, 8'h01);
    chkf("finished cleared", 1'b0, tx_finished_irq);
    chkf("empty cleared", 1'b0, tx_empty_irq);
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h84);
    rchk("status tx off", sscs_pkg::ADR_STAT, 8'h85);
  endtask
  task automatic t_standby;
    @(posedge mclk);
    standby_req <= 1'b1;
    repeat (4) @(posedge mclk);
    standby_req <= 1'b0;
    rchk("status standby", sscs_pkg::ADR_STAT, 8'h84);
    rchk("control standby", sscs_pkg::ADR_CTRL, 8'h00);
    rchk("unmapped", 5'h18, 8'h00);
  endtask
  task automatic t_rx;
    bus(1'b1, sscs_pkg::ADR_BRATE, 8'h00);
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h50);
    partner.send(10'h13c, 9, 16, 1'b0);
    chkf("full irq", 1'b1, rx_full_irq);
    rchk("rx data", sscs_pkg::ADR_RXD, 8'h3c);
    chkf("full after read", 1'b0, rx_full_irq);
    partner.send(10'h13c, 9, 16, 1'b0);
    partner.send(10'h177, 9, 16, 1'b0);
    chkf("overrun irq", 1'b1, rx_error_irq);
    rchk("status overrun", sscs_pkg::ADR_STAT, 8'he4);
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h40);
    rchk("status rx off", sscs_pkg::ADR_STAT, 8'he4);
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h50);
    rchk("old data kept", sscs_pkg::ADR_RXD, 8'h3c);
    partner.send(10'h155, 9, 16, 1'b0);
    chkf("halted on overrun", 1'b0, rx_full_irq);
    bus(1'b1, sscs_pkg::ADR_STAT, 8'h04);
    rchk("status cleared", sscs_pkg::ADR_STAT, 8'h84);
  endtask
  task automatic t_errors;
    partner.send(10'h0a5, 9, 16, 1'b0);
    rchk("status framing", sscs_pkg::ADR_STAT, 8'h94);
    chkf("no full on framing", 1'b0, rx_full_irq);
    rchk("framing data", sscs_pkg::ADR_RXD, 8'ha5);
    partner.send(10'h1c3, 9, 16, 1'b0);
    rchk("halted on framing", sscs_pkg::ADR_RXD, 8'ha5);
    bus(1'b1, sscs_pkg::ADR_STAT, 8'h04);
    bus(1'b1, sscs_pkg::ADR_MODE, 8'h08);
    partner.send(10'h1c3, 10, 16, 1'b0);
    chkf("second stop ignored", 1'b0, rx_error_irq);
    rchk("two stop data", sscs_pkg::ADR_RXD, 8'hc3);
    // the low second stop looks like a fresh start edge; drop reception to discard it
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h40);
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h50);
    bus(1'b1, sscs_pkg::ADR_MODE, 8'h20);
    partner.send(10'h33c, 10, 16, 1'b0);
    rchk("status parity", sscs_pkg::ADR_STAT, 8'h8c);
    rchk("parity data", sscs_pkg::ADR_RXD, 8'h3c);
    bus(1'b1, sscs_pkg::ADR_STAT, 8'h04);
    // same character is good under odd parity
    bus(1'b1, sscs_pkg::ADR_MODE, 8'h30);
    partner.send(10'h33c, 10, 16, 1'b0);
    chkf("odd parity full", 1'b1, rx_full_irq);
    rchk("odd parity data", sscs_pkg::ADR_RXD, 8'h3c);
    bus(1'b1, sscs_pkg::ADR_MODE, 8'h04);
    partner.send(10'h311, 10, 16, 1'b0);
    rchk("status mp bit", sscs_pkg::ADR_STAT, 8'hc6);
    rchk("mp data", sscs_pkg::ADR_RXD, 8'h11);
    bus(1'b1, sscs_pkg::ADR_CTRL, 8'h52);
    bus(1'b1, sscs_pkg::ADR_MODE, 8'h00);
    partner.send(10'h181, 9, 128, 1'b1);
    rchk("external clock data", sscs_pkg::ADR_RXD, 8'h81);
  endtask
  task automatic pin_case(input logic [7:0] c, input logic [7:0] m, input logic e);
    bus(1'b1, sscs_pkg::ADR_CTRL, c);
    bus(1'b1, sscs_pkg::ADR_MODE, m);
    repeat (3) @(posedge mclk);
    chkf("clock pin enable", e, serial_clock_pin_oe);
  endtask
  task automatic t_pins;
    int h;
    logic p;
    pin_case(8'h00, 8'h00, 1'b0);
    pin_case(8'h02, 8'h00, 1'b0);
    pin_case(8'h00, 8'h80, 1'b1);
    pin_case(8'h01, 8'h00, 1'b1);
    h = 0;
    p = serial_clock_pin_o;
    repeat (64)
    begin
      @(posedge mclk);
      if (serial_clock_pin_o === 1'b1 && p === 1'b0)
        h++;
      p = serial_clock_pin_o;
    end
    chk("clock out rises", 10'h004, h[9:0]);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rchk("status reset", sscs_pkg::ADR_STAT, 8'h84);
    t_tx();
    t_standby();
    t_rx();
    t_errors();
    t_pins();
    complete_run();
  end
endmodule
